/* logic/exc_pkg.sv */
package exc_pkg;

  // ----------------------------------------------------------------------
  // Sizes and data space map.
  // ----------------------------------------------------------------------
  localparam int NSRC = 8;
  localparam int SRC_W = 3;
  localparam logic [15:0] REGFILE_BYTES = 16'h0020;
  localparam logic [15:0] STD_IO_BYTES = 16'h0040;
  localparam logic [15:0] EXT_IO_BYTES = 16'h00a0;
  localparam logic [15:0] SRAM_START = REGFILE_BYTES + STD_IO_BYTES
                                       + EXT_IO_BYTES;
  localparam logic [15:0] SRAM_END = 16'h02ff;
  localparam logic [15:0] SP_RESET = SRAM_END;
  localparam logic [15:0] SP_USED_MASK = 16'h03ff;
  localparam logic [15:0] SP_STEP_ONE = 16'h0001;
  localparam logic [15:0] SP_STEP_TWO = 16'h0002;

  // ----------------------------------------------------------------------
  // Vectors, status bits and timing.
  // ----------------------------------------------------------------------
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_STEP = 16'h0001;
  localparam int GIE_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int ENTRY_CYCLES = 4;
  localparam int VECTOR_JUMP_CYCLES = 3;
  localparam int RETURN_CYCLES = 4;
  localparam logic [2:0] WAKE_CYCLES = 3'h4;

  // ----------------------------------------------------------------------
  // Register bus map.
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_SP_LOW = 8'h00;
  localparam logic [7:0] OFS_SP_HIGH = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ENABLE = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_LEVEL_SEL = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] LEVEL_SEL_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_OTHER = 3'h0, OP_PUSH = 3'h1, OP_CALL = 3'h2, OP_RET = 3'h3,
    OP_RETURN_FROM_INTERRUPT_INSTR = 3'h4, OP_SEI = 3'h5, OP_CLI = 3'h6
  } core_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_WAKE = 4'h1, ST_EN1 = 4'h3, ST_EN2 = 4'h2,
    ST_EN3 = 4'h6, ST_EN4 = 4'h7, ST_RT1 = 4'h5, ST_RT2 = 4'h4,
    ST_RT3 = 4'hc, ST_RT4 = 4'hd
  } exc_state_t;

  typedef struct packed {
    logic valid;
    core_op_t op;
    logic [7:0] data;
    logic [15:0] pc;
  } core_cmd_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } stack_port_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } pc_load_t;

endpackage

/* logic/cpu_interrupt_entry_and_stack.sv */
// Contract
// - Stack grows down, pointer marks top.
// - Push stores one byte, pointer minus one.
// - Call or interrupt pushes PC, pointer minus two.
// - Return pops PC, pointer plus two.
// - Pointer held in two readable writable bytes.
// - Core clock used undivided.
// - Distinct low vectors, lower address wins.
// - Take only with own and global enable.
// - Entry clears global enable.
// - Setting global enable in handler allows nesting.
// - Entry clears the served source's flag; a level-selected source keeps its flag.
// - Writing one clears flag, zero keeps it.
// - Flags stay latched while globally disabled.
// - Level requests only while condition holds.
// - One main instruction runs after return.
// - Status register never saved automatically.
// - Global disable acts at once.
// - Instruction after enable runs before interrupt.
// - Entry takes four cycles pushing PC.
// - Multi-cycle instruction finishes before entry.
// - Wake from sleep adds four cycles.
// - Return takes four cycles, sets global enable.
// - Data space map puts stack in SRAM.
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
module cpu_interrupt_entry_and_stack
  import exc_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core side.
  input wire core_cmd_t core_cmd,
  input wire logic core_sleep,
  output logic core_busy,
  output pc_load_t vector,
  output pc_load_t ret_pc,
  output logic global_enable,
  // Stack memory.
  output stack_port_t stack,
  input wire logic [7:0] stack_rdata,
  // Interrupt sources.
  input wire logic [NSRC-1:0] src_event,
  input wire logic [NSRC-1:0] src_level
);

  // ----------------------------------------------------------------------
  // Functions.
  // ----------------------------------------------------------------------
  function automatic logic [SRC_W-1:0] first_one(
    input logic [NSRC-1:0] v
  );
    first_one = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_one = SRC_W'(i);
      end
    end
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == OFS_SP_LOW) || (a == OFS_SP_HIGH) ||
              (a == OFS_STATUS) || (a == OFS_ENABLE) ||
              (a == OFS_FLAGS) || (a == OFS_LEVEL_SEL) ||
              (a == OFS_STATE);
  endfunction

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  exc_state_t state, next_state;
  logic [15:0] sp, next_sp;
  logic [7:0] status_register, next_status;
  logic [NSRC-1:0] enable, flags, level_sel;
  logic [NSRC-1:0] hw_clr, next_flags;
  logic [SRC_W-1:0] src_q, next_src;
  logic [15:0] pc_q, next_pc_q;
  logic [7:0] hi_q, next_hi;
  logic is_irq, next_irq, is_return_from_interrupt_instr, next_return_from_interrupt_instr;
  logic [2:0] wake_cnt, next_wake;
  stack_port_t next_stack;
  pc_load_t next_vector, next_ret;
  logic aw_hold, w_hold;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;

  // ----------------------------------------------------------------------
  // Register bus decode.
  // ----------------------------------------------------------------------
  wire aw_fire = awvalid & awready;
  wire w_fire = wvalid & wready;
  wire ar_fire = arvalid & arready;
  wire [ADDR_W-1:0] wr_addr = aw_hold ? aw_addr_q : awaddr;
  wire [7:0] wr_byte = w_hold ? w_byte_q : wdata[7:0];
  wire wr_lane = w_hold ? w_lane_q : wstrb[0];
  wire wr_go = (aw_hold | aw_fire) & (w_hold | w_fire) & ~bvalid;
  wire wr_en = wr_go & wr_lane & reg_hit(wr_addr);
  wire wr_sp_low = wr_en & (wr_addr == OFS_SP_LOW);
  wire wr_sp_high = wr_en & (wr_addr == OFS_SP_HIGH);
  wire wr_status = wr_en & (wr_addr == OFS_STATUS);
  wire wr_enable = wr_en & (wr_addr == OFS_ENABLE);
  wire wr_flags = wr_en & (wr_addr == OFS_FLAGS);
  wire wr_level = wr_en & (wr_addr == OFS_LEVEL_SEL);
  wire [NSRC-1:0] bus_clr = wr_flags ? wr_byte : '0;

  wire [7:0] rd_byte =
    (araddr == OFS_SP_LOW) ? sp[7:0] :
    (araddr == OFS_SP_HIGH) ? sp[15:8] :
    (araddr == OFS_STATUS) ? status_register :
    (araddr == OFS_ENABLE) ? enable :
    (araddr == OFS_FLAGS) ? flags :
    (araddr == OFS_LEVEL_SEL) ? level_sel :
    (araddr == OFS_STATE) ? {1'b0, src_q, state} : 8'h00;

  // ----------------------------------------------------------------------
  // Request qualification and arbitration.
  // ----------------------------------------------------------------------
  wire gie = status_register[GIE_BIT];
  wire [NSRC-1:0] raw_req = (level_sel & src_level)
                            | (~level_sel & flags);
  wire [NSRC-1:0] req = raw_req & enable & {NSRC{gie}};
  wire any_req = |req;
  wire [SRC_W-1:0] pick = first_one(req);
  wire is_op_other = core_cmd.valid & (core_cmd.op == OP_OTHER);
  wire is_op_cli = core_cmd.valid & (core_cmd.op == OP_CLI);
  wire is_op_sei = core_cmd.valid & (core_cmd.op == OP_SEI);
  // Entry only at the end of a finished plain instruction, or in sleep.
  wire take_now = (state == ST_IDLE) & any_req
                  & is_op_other;
  wire take_wake = (state == ST_IDLE) & any_req & core_sleep & ~core_cmd.valid;
  wire take = take_now | take_wake;
  wire [15:0] sp_bus = {wr_sp_high ? wr_byte : sp[15:8],
                        wr_sp_low ? wr_byte : sp[7:0]};
  wire [15:0] vec_addr = ({13'h0, src_q} + 16'h0001) * VECTOR_STEP;

  // ----------------------------------------------------------------------
  // Sequencer.
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_sp = sp_bus;
    next_status = wr_status ? wr_byte : status_register;
    next_src = src_q;
    next_pc_q = pc_q;
    next_hi = hi_q;
    next_irq = is_irq;
    next_return_from_interrupt_instr = is_return_from_interrupt_instr;
    next_wake = wake_cnt;
    hw_clr = '0;
    next_stack = '0;
    next_vector = '0;
    next_ret = '0;
    case (state)
      ST_IDLE: begin
        if (is_op_sei) begin
          next_status[GIE_BIT] = 1'b1;
        end
        if (is_op_cli) begin
          next_status[GIE_BIT] = 1'b0;
        end
        if (take) begin
          next_status[GIE_BIT] = 1'b0;
          next_src = pick;
          next_irq = 1'b1;
          next_pc_q = core_cmd.pc;
          hw_clr[pick] = ~level_sel[pick];
          next_wake = '0;
          next_state = take_wake ? ST_WAKE : ST_EN1;
        end else if (core_cmd.valid) begin
          case (core_cmd.op)
            OP_PUSH: begin
              next_stack.we = 1'b1;
              next_stack.addr = sp;
              next_stack.wdata = core_cmd.data;
              next_sp = (sp - SP_STEP_ONE) & SP_USED_MASK;
            end
            OP_CALL: begin
              next_irq = 1'b0;
              next_pc_q = core_cmd.pc;
              next_state = ST_EN1;
            end
            OP_RET, OP_RETURN_FROM_INTERRUPT_INSTR: begin
              next_return_from_interrupt_instr = (core_cmd.op == OP_RETURN_FROM_INTERRUPT_INSTR);
              next_state = ST_RT1;
            end
            default: begin
              next_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_WAKE: begin
        next_wake = wake_cnt + 3'h1;
        if (next_wake == WAKE_CYCLES) begin
          next_state = ST_EN1;
        end
      end
      ST_EN1: begin
        next_stack.we = 1'b1;
        next_stack.addr = sp;
        next_stack.wdata = pc_q[7:0];
        next_state = ST_EN2;
      end
      ST_EN2: begin
        next_stack.we = 1'b1;
        next_stack.addr = (sp - SP_STEP_ONE) & SP_USED_MASK;
        next_stack.wdata = pc_q[15:8];
        next_state = ST_EN3;
      end
      ST_EN3: begin
        next_sp = (sp - SP_STEP_TWO) & SP_USED_MASK;
        next_state = is_irq ? ST_EN4 : ST_IDLE;
      end
      ST_EN4: begin
        next_vector.valid = 1'b1;
        next_vector.addr = vec_addr;
        next_state = ST_IDLE;
      end
      ST_RT1: begin
        next_stack.re = 1'b1;
        next_stack.addr = (sp + SP_STEP_ONE) & SP_USED_MASK;
        next_state = ST_RT2;
      end
      ST_RT2: begin
        next_stack.re = 1'b1;
        next_stack.addr = (sp + SP_STEP_TWO) & SP_USED_MASK;
        next_state = ST_RT3;
      end
      ST_RT3: begin
        next_hi = stack_rdata;
        next_state = ST_RT4;
      end
      ST_RT4: begin
        next_ret.valid = 1'b1;
        next_ret.addr = {hi_q, stack_rdata};
        next_sp = (sp + SP_STEP_TWO) & SP_USED_MASK;
        if (is_return_from_interrupt_instr) begin
          next_status[GIE_BIT] = 1'b1;
        end
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  assign next_flags = (flags & ~bus_clr & ~hw_clr)
                      | src_event;

  // ----------------------------------------------------------------------
  // Core state registers.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      sp <= SP_RESET;
      status_register <= STATUS_RESET;
      global_enable <= 1'b0;
      enable <= ENABLE_RESET;
      level_sel <= LEVEL_SEL_RESET;
      flags <= '0;
      src_q <= '0;
      pc_q <= RESET_VECTOR;
      hi_q <= 8'h00;
      is_irq <= 1'b0;
      is_return_from_interrupt_instr <= 1'b0;
      wake_cnt <= 3'h0;
      stack <= '0;
      vector <= '0;
      ret_pc <= '0;
      core_busy <= 1'b0;
    end else begin
      state <= next_state;
      sp <= next_sp & SP_USED_MASK;
      status_register <= next_status;
      global_enable <= next_status[GIE_BIT];
      enable <= wr_enable ? wr_byte : enable;
      level_sel <= wr_level ? wr_byte : level_sel;
      flags <= next_flags;
      src_q <= next_src;
      pc_q <= next_pc_q;
      hi_q <= next_hi;
      is_irq <= next_irq;
      is_return_from_interrupt_instr <= next_return_from_interrupt_instr;
      wake_cnt <= next_wake;
      stack <= next_stack;
      vector <= next_vector;
      ret_pc <= next_ret;
      core_busy <= (next_state != ST_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // Register bus write channel.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_addr_q <= awaddr;
        awready <= 1'b0;
      end else if (bvalid & bready) begin
        awready <= 1'b1;
      end
      if (w_fire) begin
        w_byte_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
        wready <= 1'b0;
      end else if (bvalid & bready) begin
        wready <= 1'b1;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= reg_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end else begin
        aw_hold <= aw_hold | aw_fire;
        w_hold <= w_hold | w_fire;
        if (bready) begin
          bvalid <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register bus read channel.
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      if (ar_fire) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_byte};
        rresp <= reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid & rready) begin
        arready <= 1'b1;
        rvalid <= 1'b0;
      end
    end
  end

endmodule

/* verification/periph_model.sv */
module periph_model
  import exc_pkg::*;
(
  // Clock.
  input wire logic aclk,
  // Stack memory.
  input wire stack_port_t stack,
  output logic [7:0] stack_rdata = 8'h00,
  // Requests.
  output logic [NSRC-1:0] src_event = '0,
  output logic [NSRC-1:0] src_level = '0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:1023];
  // ----------------------------------------------------------------
  // Stack memory and request sources.
  // ----------------------------------------------------------------
  // Read data is good for one cycle only, then it is scrambled.
  always @(posedge aclk) begin
    if (stack.we) mem[stack.addr[9:0]] <= stack.wdata;
    stack_rdata <= stack.re ? mem[stack.addr[9:0]] : ~stack_rdata;
  end
  task automatic fire(input int i);
    @(posedge aclk);
    src_event[i] <= 1'b1;
    @(posedge aclk);
    src_event[i] <= 1'b0;
  endtask
  task automatic lvl(input int i, input logic v);
    src_level[i] <= v;
  endtask
endmodule

/* verification/cpu_interrupt_entry_and_stack_chk.sv */
module exc_chk
  import exc_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Core side.
  input wire core_cmd_t core_cmd,
  input wire logic core_busy,
  input wire pc_load_t vector,
  input wire pc_load_t ret_pc,
  input wire logic global_enable,
  input wire stack_port_t stack
);
  // ----------------------------------------------------------------
  // Core side timing checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic take;
  assign take = core_cmd.valid && !core_busy;
  a_push_store: assert property (take && core_cmd.op == OP_PUSH |=>
    stack.we && stack.wdata == $past(core_cmd.data))
    else $error("push byte not stored");
  a_stack_down: assert property (stack.we && $past(stack.we) |->
    stack.addr == $past(stack.addr) - 16'h0001)
    else $error("stack write not descending");
  a_pop_up: assert property (stack.re && $past(stack.re) |->
    stack.addr == $past(stack.addr) + 16'h0001)
    else $error("stack read not ascending");
  a_entry_time: assert property (vector.valid |->
    $past(stack.we, 2) && $past(stack.we, 3) && $past(core_busy, 4))
    else $error("entry timing wrong");
  a_entry_gie: assert property (vector.valid |-> !global_enable)
    else $error("global enable left set on entry");
  a_ret_time: assert property (ret_pc.valid |->
    $past(stack.re, 2) && $past(stack.re, 3))
    else $error("return timing wrong");
  a_return_from_interrupt_instr_gie: assert property (take && core_cmd.op == OP_RETURN_FROM_INTERRUPT_INSTR |->
    ##5 ret_pc.valid && global_enable)
    else $error("return did not set global enable");
  a_cli_now: assert property (take && core_cmd.op == OP_CLI ##1
    !core_cmd.valid |-> !global_enable ##1 (!global_enable && !core_busy))
    else $error("disable not immediate");
  a_sei_next: assert property (take && core_cmd.op == OP_SEI |=>
    !core_busy)
    else $error("entry right after enable");
  a_ret_gap: assert property (ret_pc.valid && !core_cmd.valid |->
    !core_busy ##1 !core_busy)
    else $error("entry right after return");
endmodule
bind cpu_interrupt_entry_and_stack exc_chk chk_u (.aclk, .aresetn,
  .core_cmd, .core_busy, .vector, .ret_pc, .global_enable, .stack);

/* verification/test_cpu_interrupt_entry_and_stack.sv */
module test_cpu_interrupt_entry_and_stack
  import exc_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0, aresetn = 1'b0, core_sleep = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid;
  logic arready, rvalid, core_busy, global_enable;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  core_cmd_t core_cmd = '0;
  pc_load_t vector, ret_pc;
  stack_port_t stack;
  logic [7:0] stack_rdata;
  logic [NSRC-1:0] src_event, src_level;
  int compares = 0, n_mismatch = 0, cyc = 0, nb = 0;
  cpu_interrupt_entry_and_stack dut_u (
    .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .core_cmd, .core_sleep, .core_busy, .vector, .ret_pc, .global_enable,
    .stack, .stack_rdata, .src_event, .src_level);
  periph_model peri_u (.aclk, .stack, .stack_rdata, .src_event, .src_level);
  // ----------------------------------------------------------------
  // Bus and core tasks.
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d,
                    input logic [1:0] er = RESP_OKAY);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk("rdata", rdata, e);
    chk("rresp", rresp, er);
  endtask
  task automatic cmd(input core_op_t op, input logic [15:0] pc = 16'h0);
    while (core_busy) @(posedge aclk);
    core_cmd <= '{1'b1, op, 8'ha5, pc};
    @(posedge aclk);
    core_cmd <= '{1'b0, OP_OTHER, 8'h00, pc};
    @(posedge aclk);
  endtask
  task automatic wv(input logic [15:0] e, input int n);
    do @(posedge aclk); while (!vector.valid);
    chk("vector", vector.addr, e);
    chk("busy_cycles", nb, n);
  endtask
  task automatic wret(input logic [15:0] e);
    do @(posedge aclk); while (!ret_pc.valid);
    chk("ret_pc", ret_pc.addr, e);
  endtask
  task automatic nv;
    repeat (6) begin
      @(posedge aclk);
      chk("no_entry", core_busy, 1'b0);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    nb <= core_busy ? nb + 1 : 0;
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFS_SP_LOW, 32'hff);
    rc(OFS_SP_HIGH, 32'h02);
    rc(OFS_STATUS, 32'h00);
    wr(8'h1c, 8'h11, RESP_SLVERR);
    rc(8'h1c, 32'h00, RESP_SLVERR);
    $display("test reset done");
    wr(OFS_SP_HIGH, 8'h02);
    wr(OFS_SP_LOW, 8'h00);
    wstrb <= 4'h0;
    wr(OFS_SP_LOW, 8'h55);
    wstrb <= 4'hf;
    rc(OFS_SP_LOW, 32'h00);
    cmd(OP_PUSH);
    @(posedge aclk);
    chk("push", peri_u.mem[10'h200], 8'ha5);
    rc(OFS_SP_LOW, 32'hff);
    rc(OFS_SP_HIGH, 32'h01);
    cmd(OP_CALL, 16'h0abc);
    repeat (4) @(posedge aclk);
    rc(OFS_SP_LOW, 32'hfd);
    chk("call_lo", peri_u.mem[10'h1ff], 8'hbc);
    chk("call_hi", peri_u.mem[10'h1fe], 8'h0a);
    cmd(OP_RET);
    wret(16'h0abc);
    chk("gie", global_enable, 1'b0);
    rc(OFS_SP_LOW, 32'hff);
    $display("test stack done");
    wr(OFS_ENABLE, 8'h06);
    peri_u.fire(2);
    peri_u.fire(1);
    cmd(OP_OTHER);
    nv();
    rc(OFS_FLAGS, 32'h06);
    wr(OFS_STATUS, 8'h05);
    cmd(OP_SEI);
    cmd(OP_OTHER, 16'h1234);
    wv(16'h0002, 4);
    chk("st_lo", peri_u.mem[10'h1ff], 8'h34);
    chk("st_hi", peri_u.mem[10'h1fe], 8'h12);
    rc(OFS_SP_LOW, 32'hfd);
    rc(OFS_STATUS, 32'h05);
    rc(OFS_FLAGS, 32'h04);
    $display("test flags done");
    wr(OFS_STATUS, 8'h85);
    cmd(OP_OTHER, 16'h0040);
    wv(16'h0003, 4);
    cmd(OP_RETURN_FROM_INTERRUPT_INSTR);
    wret(16'h0040);
    chk("gie", global_enable, 1'b1);
    rc(OFS_SP_LOW, 32'hfd);
    cmd(OP_RETURN_FROM_INTERRUPT_INSTR);
    wret(16'h1234);
    rc(OFS_SP_LOW, 32'hff);
    rc(OFS_STATUS, 32'h85);
    peri_u.fire(0);
    wr(OFS_FLAGS, 8'h00);
    rc(OFS_FLAGS, 32'h01);
    wr(OFS_FLAGS, 8'h01);
    rc(OFS_FLAGS, 32'h00);
    $display("test nest done");
    wr(OFS_LEVEL_SEL, 8'h08);
    peri_u.lvl(3, 1'b1);
    @(posedge aclk);
    peri_u.lvl(3, 1'b0);
    wr(OFS_ENABLE, 8'h08);
    cmd(OP_OTHER);
    nv();
    peri_u.lvl(3, 1'b1);
    cmd(OP_CLI);
    nv();
    cmd(OP_OTHER);
    nv();
    cmd(OP_SEI);
    core_cmd <= '{1'b0, OP_OTHER, 8'h00, 16'h0077};
    core_sleep <= 1'b1;
    wv(16'h0004, 8);
    core_sleep <= 1'b0;
    peri_u.lvl(3, 1'b0);
    chk("wake_lo", peri_u.mem[10'h1ff], 8'h77);
    cmd(OP_RETURN_FROM_INTERRUPT_INSTR);
    wret(16'h0077);
    rc(OFS_SP_LOW, 32'hff);
    $display("test level done");
    summarize();
  end
endmodule
